// ==== core/pwc_pkg.sv ====
`default_nettype none
package pwc_pkg;
   // geometry
   localparam int PWC_NMOD = 3;
   localparam int PWC_CMP_W = 12;
   localparam int PWC_CMP_COUNT = 10;
   localparam int PWC_RB_IDX = 9;
   localparam int PWC_FILT_LEN = 4;
   // byte offsets on the register bus
   localparam logic [7:0] PWC_ADDR_CONFIG = 8'h00;
   localparam logic [7:0] PWC_ADDR_CONTROL = 8'h04;
   localparam logic [7:0] PWC_ADDR_FAULT0 = 8'h08;
   localparam logic [7:0] PWC_ADDR_MASK = 8'h14;
   localparam logic [7:0] PWC_ADDR_FLAGS = 8'h18;
   localparam logic [7:0] PWC_ADDR_OUTEN = 8'h1C;
   localparam logic [7:0] PWC_ADDR_CMP = 8'h40;
   // pwm_config bits
   localparam int PWC_CFG_LOCK = 5;
   localparam int PWC_CFG_MODE = 4;
   localparam int PWC_CFG_POLB = 3;
   localparam int PWC_CFG_POLA = 2;
   localparam logic [7:0] PWC_CFG_MASK = 8'h3C;
   // pwm_control bits
   localparam int PWC_CTL_DIV_HI = 7;
   localparam int PWC_CTL_DIV_LO = 6;
   localparam int PWC_CTL_CLKSEL = 5;
   localparam int PWC_CTL_FINISH = 1;
   localparam int PWC_CTL_RUN = 0;
   localparam logic [7:0] PWC_CTL_MASK = 8'hE3;
   // fault_input_control bits
   localparam int PWC_FIC_GUARD_OFF = 7;
   localparam int PWC_FIC_SRC = 6;
   localparam int PWC_FIC_LEVEL = 5;
   localparam int PWC_FIC_FILT = 4;
   localparam int PWC_FIC_ASYNC = 3;
   // interrupt_mask / interrupt_flags bits
   localparam int PWC_IRQ_CYCLE = 0;
   localparam int PWC_IRQ_EV0 = 1;
   localparam logic [7:0] PWC_IRQ_MASK = 8'h0F;
   localparam logic [7:0] PWC_OUTEN_MASK = 8'h3F;
   // prescaler
   localparam logic [1:0] PWC_DIV_1 = 2'h0;
   localparam logic [1:0] PWC_DIV_4 = 2'h1;
   localparam logic [1:0] PWC_DIV_32 = 2'h2;
   localparam logic [7:0] PWC_DIV4_LAST = 8'h03;
   localparam logic [7:0] PWC_DIV32_LAST = 8'h1F;
   localparam logic [7:0] PWC_DIV256_LAST = 8'hFF;
   // fault action codes
   localparam logic [2:0] PWC_FM_IGNORE = 3'h0;
   localparam logic [2:0] PWC_FM_OFF_A = 3'h1;
   localparam logic [2:0] PWC_FM_OFF_B = 3'h2;
   localparam logic [2:0] PWC_FM_OFF_AB = 3'h3;
   localparam logic [1:0] PWC_FM_ALL = 2'h2;
   localparam logic [1:0] PWC_FM_HALT = 2'h3;
   // run sequencer
   typedef enum logic [2:0] {
      PWC_IDLE = 3'h1,
      PWC_RUN = 3'h2,
      PWC_DRAIN = 3'h4
   } pwc_run_t;
endpackage
`default_nettype wire

// ==== core/pwc_core.sv ====
// Behaviour
// - ten 12-bit compare values compared continuously with the counter
// - high byte staged in shared holding register, committed with low byte
// - lock bit holds working copies; they load when lock returns to zero
// - mode bit: zero ramp edge-aligned, one center-aligned counting
// - b_polarity: zero makes B outputs active low, one active high
// - a_polarity: zero makes A outputs active low, one active high
// - prescaler field divides selected clock by 1, 4, 32 or 256
// - clock_source_sel: one uses PLL clock, zero uses I/O clock
// - with finish bit, clearing run completes current cycle, else halts immediately
// - writing one to run bit starts counter and waveforms
// - overlap_guard_off disables protection against A and B both active
// - source select: zero fault pin, one comparator output of module
// - level select: zero low level is fault, one high level
// - filter on: input changes only after four equal consecutive samples
// - async control zero: fault acts directly on module A and B outputs
// - fault action: ignore, kill A, kill B, kill both, kill all, halt
// - per-module event enable routes fault events to interrupt request
// - cycle-end enable requests interrupt at each completed cycle
// - hardware sets event and cycle-end flags, readable regardless of enables
// - flags cleared by writing one; writing zero leaves them unchanged
// - cycle end signalled at counter match with B reset point
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pwc_core
   import pwc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // timebase source enables, one-cycle pulses
   input wire logic clk_io_en,
   input wire logic clk_pll_en,
   // fault inputs
   input wire logic [PWC_NMOD-1:0] fault_input_pin,
   input wire logic [PWC_NMOD-1:0] comp_out,
   // waveform outputs and pin enables
   output logic [PWC_NMOD-1:0] out_a,
   output logic [PWC_NMOD-1:0] out_b,
   output logic [2*PWC_NMOD-1:0] out_pin_en,
   // status and interrupt requests
   output logic running,
   output logic irq_fault,
   output logic irq_cycle_end
);
   logic [7:0] cfg_reg;
   logic [7:0] ctl_reg;
   logic [7:0] fic_reg [PWC_NMOD];
   logic [7:0] mask_reg;
   logic [3:0] flags_reg;
   logic [7:0] outen_reg;
   logic [7:0] outen_w_reg;
   logic [7:0] temp_reg;
   logic [PWC_CMP_W-1:0] cmp_reg [PWC_CMP_COUNT];
   logic [PWC_CMP_W-1:0] cmp_w_reg [PWC_CMP_COUNT];
   logic [7:0] pre_reg;
   logic [PWC_CMP_W-1:0] cnt_reg;
   logic down_reg;
   pwc_run_t state_reg;
   logic [PWC_NMOD-1:0] a_reg;
   logic [PWC_NMOD-1:0] b_reg;
   logic [PWC_NMOD-1:0] ev_prev_reg;
   logic [PWC_NMOD-1:0] ev_sync;
   logic [PWC_NMOD-1:0] ev_out;
   logic [PWC_NMOD-1:0] ev_pulse;
   logic [PWC_NMOD-1:0] halt_req;
   logic [PWC_NMOD-1:0] kill_a;
   logic [PWC_NMOD-1:0] kill_b;
   logic [PWC_NMOD-1:0] kill_all;
   logic [PWC_NMOD-1:0] a_act;
   logic [PWC_NMOD-1:0] b_act;
   logic wr;
   logic rd_setup;
   logic [7:0] cmp_off;
   logic [3:0] cmp_idx;
   logic cmp_hit;
   logic fic_hit;
   logic [1:0] fic_idx;
   logic mapped;
   logic src_en;
   logic tick;
   logic [7:0] pre_last;
   logic [PWC_CMP_W-1:0] rb_w;
   logic cycle_end;
   logic halt_any;
   logic [31:0] rdata;

   // bus decode; always ready, so every access phase is one cycle
   assign pready = 1'b1;
   assign wr = psel && penable && pwrite;
   assign rd_setup = psel && !penable;
   assign cmp_off = paddr - PWC_ADDR_CMP;
   assign cmp_idx = cmp_off[6:3];
   assign cmp_hit = (paddr >= PWC_ADDR_CMP) && (cmp_off[7] == 1'b0) && (cmp_idx < 4'(PWC_CMP_COUNT));
   assign fic_hit = (paddr >= PWC_ADDR_FAULT0) && (paddr < PWC_ADDR_MASK);
   assign fic_idx = 2'((paddr - PWC_ADDR_FAULT0) >> 2);
   assign mapped = (paddr[1:0] == 2'h0) && (cmp_hit || fic_hit || paddr == PWC_ADDR_CONFIG
      || paddr == PWC_ADDR_CONTROL || paddr == PWC_ADDR_MASK || paddr == PWC_ADDR_FLAGS
      || paddr == PWC_ADDR_OUTEN);
   assign pslverr = psel && penable && !mapped;

   // read mux; reserved bits are zero because the registers hold zeros there
   always_comb
   begin
      rdata = 32'h0;
      if (cmp_hit)
      begin
         if (cmp_off[2])
            rdata[3:0] = cmp_reg[cmp_idx][PWC_CMP_W-1:8];
         else
            rdata[7:0] = cmp_reg[cmp_idx][7:0];
      end
      else if (fic_hit)
         rdata[7:0] = fic_reg[fic_idx];
      else if (paddr == PWC_ADDR_CONFIG)
         rdata[7:0] = cfg_reg;
      else if (paddr == PWC_ADDR_CONTROL)
         rdata[7:0] = ctl_reg;
      else if (paddr == PWC_ADDR_MASK)
         rdata[7:0] = mask_reg;
      else if (paddr == PWC_ADDR_FLAGS)
         rdata[3:0] = flags_reg;
      else if (paddr == PWC_ADDR_OUTEN)
         rdata[7:0] = outen_reg;
   end

   // read data captured in the setup cycle so it comes from a flip-flop
   always_ff @(posedge clk)
   begin
      if (reset)
         prdata <= 32'h0;
      else if (rd_setup && !pwrite && mapped)
         prdata <= rdata;
      else if (rd_setup)
         prdata <= 32'h0;
   end

   // plain control registers, masked so unused bits stay zero
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         cfg_reg <= 8'h0;
         mask_reg <= 8'h0;
         outen_reg <= 8'h0;
      end
      else if (wr)
      begin
         if (paddr == PWC_ADDR_CONFIG)
            cfg_reg <= pwdata[7:0] & PWC_CFG_MASK;
         if (paddr == PWC_ADDR_MASK)
            mask_reg <= pwdata[7:0] & PWC_IRQ_MASK;
         if (paddr == PWC_ADDR_OUTEN)
            outen_reg <= pwdata[7:0] & PWC_OUTEN_MASK;
      end
   end

   // control register; a halting fault drops the run bit and waits for software
   always_ff @(posedge clk)
   begin
      if (reset)
         ctl_reg <= 8'h0;
      else if (wr && paddr == PWC_ADDR_CONTROL)
         ctl_reg <= pwdata[7:0] & PWC_CTL_MASK;
      else if (halt_any)
         ctl_reg[PWC_CTL_RUN] <= 1'b0;
   end

   // per-module fault configuration
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         for (int m = 0; m < PWC_NMOD; m++)
            fic_reg[m] <= 8'h0;
      end
      else if (wr && fic_hit && paddr[1:0] == 2'h0)
         fic_reg[fic_idx] <= pwdata[7:0];
   end

   // wide compare writes: high byte parks in the shared holding register,
   // low byte write commits both halves at once
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         temp_reg <= 8'h0;
         for (int i = 0; i < PWC_CMP_COUNT; i++)
            cmp_reg[i] <= '0;
      end
      else if (wr && cmp_hit && paddr[1:0] == 2'h0)
      begin
         if (cmp_off[2])
            temp_reg <= pwdata[7:0];
         else
            cmp_reg[cmp_idx] <= {temp_reg[3:0], pwdata[7:0]};
      end
   end

   // working copies follow the software copies only while unlocked
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         outen_w_reg <= 8'h0;
         for (int i = 0; i < PWC_CMP_COUNT; i++)
            cmp_w_reg[i] <= '0;
      end
      else if (!cfg_reg[PWC_CFG_LOCK])
      begin
         outen_w_reg <= outen_reg;
         for (int i = 0; i < PWC_CMP_COUNT; i++)
            cmp_w_reg[i] <= cmp_reg[i];
      end
   end
   assign out_pin_en = outen_w_reg[2*PWC_NMOD-1:0];

   // prescaler on the selected source enable
   assign src_en = ctl_reg[PWC_CTL_CLKSEL] ? clk_pll_en : clk_io_en;
   always_comb
   begin
      unique case (ctl_reg[PWC_CTL_DIV_HI:PWC_CTL_DIV_LO])
         PWC_DIV_1: pre_last = 8'h0;
         PWC_DIV_4: pre_last = PWC_DIV4_LAST;
         PWC_DIV_32: pre_last = PWC_DIV32_LAST;
         default: pre_last = PWC_DIV256_LAST;
      endcase
   end
   assign tick = src_en && (pre_reg == pre_last);
   always_ff @(posedge clk)
   begin
      if (reset || state_reg == PWC_IDLE)
         pre_reg <= 8'h0;
      else if (tick)
         pre_reg <= 8'h0;
      else if (src_en)
         pre_reg <= pre_reg + 8'h01;
   end

   // counter: ramp wraps at the B reset point, center turns round there
   assign rb_w = cmp_w_reg[PWC_RB_IDX];
   assign cycle_end = (state_reg != PWC_IDLE) && tick && (cnt_reg == rb_w) && !down_reg;
   always_ff @(posedge clk)
   begin
      if (reset || state_reg == PWC_IDLE)
      begin
         cnt_reg <= '0;
         down_reg <= 1'b0;
      end
      else if (tick)
      begin
         if (!cfg_reg[PWC_CFG_MODE])
            cnt_reg <= (cnt_reg == rb_w) ? '0 : cnt_reg + 12'h001;
         else if (down_reg)
         begin
            down_reg <= (cnt_reg != 12'h001) && (cnt_reg != '0);
            cnt_reg <= (cnt_reg == '0) ? cnt_reg : cnt_reg - 12'h001;
         end
         else if (cnt_reg == rb_w && rb_w != '0)
         begin
            down_reg <= 1'b1;
            cnt_reg <= cnt_reg - 12'h001;
         end
         else
            cnt_reg <= (cnt_reg == rb_w) ? cnt_reg : cnt_reg + 12'h001;
      end
   end

   // run sequencer; drain state lets the current cycle finish
   always_ff @(posedge clk)
   begin
      if (reset)
         state_reg <= PWC_IDLE;
      else
      begin
         unique case (state_reg)
            PWC_IDLE:
               if (ctl_reg[PWC_CTL_RUN] && !halt_any)
                  state_reg <= PWC_RUN;
            PWC_RUN:
               if (halt_any)
                  state_reg <= PWC_IDLE;
               else if (!ctl_reg[PWC_CTL_RUN])
                  state_reg <= ctl_reg[PWC_CTL_FINISH] ? PWC_DRAIN : PWC_IDLE;
            PWC_DRAIN:
               if (halt_any || cycle_end)
                  state_reg <= PWC_IDLE;
               else if (ctl_reg[PWC_CTL_RUN])
                  state_reg <= PWC_RUN;
         endcase
      end
   end
   assign running = (state_reg != PWC_IDLE);

   // fault input conditioning, one slice per module
   generate
      for (genvar m = 0; m < PWC_NMOD; m++)
      begin : g_mod
         logic sel_in;
         logic smp_reg;
         logic filt_reg;
         logic [PWC_FILT_LEN-1:0] hist_reg;
         logic [2:0] mode;
         logic act;
         assign sel_in = fic_reg[m][PWC_FIC_SRC] ? comp_out[m] : fault_input_pin[m];
         assign mode = fic_reg[m][2:0];
         // the filter only moves after a full run of equal samples
         always_ff @(posedge clk)
         begin
            if (reset)
            begin
               smp_reg <= 1'b0;
               hist_reg <= '0;
               filt_reg <= 1'b0;
            end
            else
            begin
               smp_reg <= sel_in;
               hist_reg <= {hist_reg[PWC_FILT_LEN-2:0], sel_in};
               if (&hist_reg)
                  filt_reg <= 1'b1;
               else if (~|hist_reg)
                  filt_reg <= 1'b0;
            end
         end
         assign ev_sync[m] = (fic_reg[m][PWC_FIC_FILT] ? filt_reg : smp_reg) == fic_reg[m][PWC_FIC_LEVEL];
         // the direct path skips filter and sampling to react within the cycle
         assign act = fic_reg[m][PWC_FIC_ASYNC] ? ev_sync[m] : (sel_in == fic_reg[m][PWC_FIC_LEVEL]);
         assign ev_out[m] = act && (mode != PWC_FM_IGNORE);
         assign ev_pulse[m] = ev_sync[m] && !ev_prev_reg[m] && (mode != PWC_FM_IGNORE);
         assign kill_a[m] = ev_out[m] && (mode == PWC_FM_OFF_A || mode == PWC_FM_OFF_AB);
         assign kill_b[m] = ev_out[m] && (mode == PWC_FM_OFF_B || mode == PWC_FM_OFF_AB);
         assign kill_all[m] = ev_out[m] && (mode[2:1] == PWC_FM_ALL);
         assign halt_req[m] = ev_pulse[m] && (mode[2:1] == PWC_FM_HALT);
      end
   endgenerate
   assign halt_any = |halt_req;

   always_ff @(posedge clk)
   begin
      if (reset)
         ev_prev_reg <= '0;
      else
         ev_prev_reg <= ev_sync;
   end

   // waveform edges from compare matches: set A at index 3m, reset A at 3m+1,
   // set B at 3m+2, reset B at the shared B reset point
   always_ff @(posedge clk)
   begin
      if (reset || state_reg == PWC_IDLE)
      begin
         a_reg <= '0;
         b_reg <= '0;
      end
      else if (tick)
      begin
         for (int m = 0; m < PWC_NMOD; m++)
         begin
            if (cnt_reg == cmp_w_reg[3*m+1])
               a_reg[m] <= 1'b0;
            else if (cnt_reg == cmp_w_reg[3*m])
               a_reg[m] <= 1'b1;
            if (cnt_reg == rb_w)
               b_reg[m] <= 1'b0;
            else if (cnt_reg == cmp_w_reg[3*m+2])
               b_reg[m] <= 1'b1;
         end
      end
   end

   // output gating; A wins an overlap unless the guard is switched off
   always_comb
   begin
      for (int m = 0; m < PWC_NMOD; m++)
      begin
         a_act[m] = a_reg[m] && !kill_a[m] && !(|kill_all);
         b_act[m] = b_reg[m] && !kill_b[m] && !(|kill_all)
            && (fic_reg[m][PWC_FIC_GUARD_OFF] || !a_act[m]);
         out_a[m] = cfg_reg[PWC_CFG_POLA] ? a_act[m] : !a_act[m];
         out_b[m] = cfg_reg[PWC_CFG_POLB] ? b_act[m] : !b_act[m];
      end
   end

   // sticky flags: a set in the clearing cycle wins
   always_ff @(posedge clk)
   begin
      if (reset)
         flags_reg <= 4'h0;
      else
         flags_reg <= (flags_reg & ~((wr && paddr == PWC_ADDR_FLAGS) ? pwdata[3:0] : 4'h0))
            | {ev_pulse, cycle_end};
   end
   assign irq_cycle_end = flags_reg[PWC_IRQ_CYCLE] && mask_reg[PWC_IRQ_CYCLE];
   assign irq_fault = |(flags_reg[3:PWC_IRQ_EV0] & mask_reg[3:PWC_IRQ_EV0]);

   property p_commit;
      @(posedge clk) disable iff (reset)
      wr && cmp_hit && !cmp_off[2] && paddr[1:0] == 2'h0 && cmp_idx == 4'(PWC_RB_IDX)
         |=> cmp_reg[PWC_RB_IDX] == {$past(temp_reg[3:0]), $past(pwdata[7:0])};
   endproperty
   a_commit: assert property (p_commit) else $error("compare low write did not commit staged high");

   property p_lock;
      @(posedge clk) disable iff (reset)
      cfg_reg[PWC_CFG_LOCK] && $past(cfg_reg[PWC_CFG_LOCK]) |-> $stable(cmp_w_reg[PWC_RB_IDX]);
   endproperty
   a_lock: assert property (p_lock) else $error("working compare changed while locked");

   property p_w1c;
      @(posedge clk) disable iff (reset)
      wr && paddr == PWC_ADDR_FLAGS && pwdata[PWC_IRQ_CYCLE] && !cycle_end |=> !flags_reg[PWC_IRQ_CYCLE];
   endproperty
   a_w1c: assert property (p_w1c) else $error("cycle flag not cleared by write of one");

   property p_set;
      @(posedge clk) disable iff (reset)
      cycle_end |=> flags_reg[PWC_IRQ_CYCLE];
   endproperty
   a_set: assert property (p_set) else $error("cycle end did not set its flag");

   property p_div4;
      @(posedge clk) disable iff (reset)
      tick && ctl_reg[PWC_CTL_DIV_HI:PWC_CTL_DIV_LO] == PWC_DIV_4
         |=> (!tick || ctl_reg[PWC_CTL_DIV_HI:PWC_CTL_DIV_LO] != PWC_DIV_4) [*3];
   endproperty
   a_div4: assert property (p_div4) else $error("divide by four tick misplaced");

   property p_start;
      @(posedge clk) disable iff (reset)
      state_reg == PWC_IDLE && wr && paddr == PWC_ADDR_CONTROL && pwdata[PWC_CTL_RUN] && !halt_any
         ##1 !halt_any |=> state_reg == PWC_RUN;
   endproperty
   a_start: assert property (p_start) else $error("run write did not start the counter");

   property p_stop;
      @(posedge clk) disable iff (reset)
      state_reg == PWC_RUN && !ctl_reg[PWC_CTL_RUN] && !ctl_reg[PWC_CTL_FINISH] |=> state_reg == PWC_IDLE;
   endproperty
   a_stop: assert property (p_stop) else $error("plain stop did not halt at once");

   property p_overlap;
      @(posedge clk) disable iff (reset)
      !fic_reg[1][PWC_FIC_GUARD_OFF] |-> !(a_act[1] && b_act[1]);
   endproperty
   a_overlap: assert property (p_overlap) else $error("A and B active together with guard on");

   property p_ramp;
      @(posedge clk) disable iff (reset)
      cycle_end && !cfg_reg[PWC_CFG_MODE] && state_reg == PWC_RUN |=> cnt_reg == '0;
   endproperty
   a_ramp: assert property (p_ramp) else $error("ramp did not wrap at B reset point");
endmodule
`default_nettype wire

// ==== testbench/pwc_core_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module pwc_core_tb;
   import pwc_pkg::*;
   logic clk, reset, psel, penable, pwrite, pready, pslverr, slv;
   logic clk_io_en = 1'b0;
   logic clk_pll_en, running, irq_fault, irq_cycle_end;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0] fault_input_pin, comp_out, out_a, out_b, seen;
   logic [5:0] out_pin_en;
   int num_errors = 0;
   int comparisons = 0;
   int cyc = 0;
   int n, t0;
   pwc_core DUT (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .clk_io_en(clk_io_en), .clk_pll_en(clk_pll_en), .fault_input_pin(fault_input_pin),
      .comp_out(comp_out), .out_a(out_a), .out_b(out_b), .out_pin_en(out_pin_en),
      .running(running), .irq_fault(irq_fault), .irq_cycle_end(irq_cycle_end));
   // 200 MHz clock; io rate is half of it so the two sources give different periods
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      clk_io_en <= ~clk_io_en;
   end
   task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(what, rd, exp);
   endtask
   // high byte goes to the shared holding register first, low byte commits
   task automatic wr_cmp(input int idx, input logic [11:0] v);
      apb(1'b1, 8'(32'h44 + idx * 8), {28'h0, v[11:8]});
      apb(1'b1, 8'(32'h40 + idx * 8), {24'h0, v[7:0]});
   endtask
   // bounded wait, sampled mid-cycle so the edge's updates have landed
   task automatic wait_end();
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end
      while (irq_cycle_end !== 1'b1 && n < 5000);
      check("cycle wait", {31'h0, irq_cycle_end}, 32'h1);
   endtask
   task automatic period(input logic [7:0] ctl, input int exp);
      apb(1'b1, PWC_ADDR_CONTROL, {24'h0, ctl});
      wait_end();
      t0 = cyc;
      apb(1'b1, PWC_ADDR_FLAGS, 32'h1);
      wait_end();
      check("period", 32'(cyc - t0), 32'(exp));
      apb(1'b1, PWC_ADDR_CONTROL, 32'h0);
      apb(1'b1, PWC_ADDR_FLAGS, 32'h1);
   endtask
   task automatic t_regs();
      for (int a = 0; a < 8; a++)
         rdchk("reset value", 8'(a * 4), 32'h0);
      check("reset ab", {26'h0, out_a, out_b}, 32'h3F);
      apb(1'b1, PWC_ADDR_CONFIG, 32'hFF);
      check("config err", {31'h0, slv}, 32'h0);
      rdchk("config", PWC_ADDR_CONFIG, 32'h3C);
      apb(1'b1, PWC_ADDR_CONTROL, 32'hFC);
      rdchk("control", PWC_ADDR_CONTROL, 32'hE0);
      apb(1'b1, PWC_ADDR_MASK, 32'hFF);
      rdchk("mask", PWC_ADDR_MASK, 32'h0F);
      apb(1'b1, 8'h0C, 32'hA5);
      rdchk("fault ctl", 8'h0C, 32'hA5);
      rdchk("unmapped", 8'h30, 32'h0);
      check("unmapped err", {31'h0, slv}, 32'h1);
      apb(1'b1, PWC_ADDR_CONTROL, 32'h0);
      apb(1'b1, 8'h0C, 32'h0);
      $display("done regs");
   endtask
   task automatic t_stage();
      wr_cmp(9, 12'hA34);
      apb(1'b1, 8'h8C, 32'h3);
      rdchk("rb high", 8'h8C, 32'h0A);
      apb(1'b1, 8'h88, 32'h56);
      rdchk("rb low", 8'h88, 32'h56);
      rdchk("rb high", 8'h8C, 32'h03);
      wr_cmp(9, 12'h007);
      // config still holds the lock from the register test; release it so the copies follow
      apb(1'b1, PWC_ADDR_CONFIG, 32'h0);
      $display("done staging");
   endtask
   task automatic t_timebase();
      apb(1'b1, PWC_ADDR_MASK, 32'h1);
      period(8'h21, 8);
      period(8'h01, 16);
      period(8'h61, 32);
      period(8'hA1, 256);
      period(8'hE1, 2048);
      apb(1'b1, PWC_ADDR_CONFIG, 32'h10);
      period(8'h21, 14);
      apb(1'b1, PWC_ADDR_CONFIG, 32'h0);
      $display("done timebase");
   endtask
   task automatic t_halt();
      apb(1'b1, PWC_ADDR_CONTROL, 32'h63);
      wait_end();
      apb(1'b1, PWC_ADDR_FLAGS, 32'h1);
      apb(1'b1, PWC_ADDR_FLAGS, 32'h0);
      apb(1'b1, PWC_ADDR_CONTROL, 32'h62);
      check("running", {31'h0, running}, 32'h1);
      for (n = 0; n < 64 && running === 1'b1; n++)
         @(negedge clk);
      check("cycle done", {31'h0, irq_cycle_end}, 32'h1);
      apb(1'b1, PWC_ADDR_CONTROL, 32'h61);
      apb(1'b1, PWC_ADDR_CONTROL, 32'h60);
      repeat (2) @(negedge clk);
      check("stopped", {31'h0, running}, 32'h0);
      $display("done halt");
   endtask
   task automatic t_fault();
      wr_cmp(3, 12'h001);
      wr_cmp(4, 12'h005);
      apb(1'b1, PWC_ADDR_CONFIG, 32'h0C);
      @(negedge clk);
      check("idle ab", {26'h0, out_a, out_b}, 32'h0);
      apb(1'b1, PWC_ADDR_MASK, 32'h06);
      apb(1'b1, PWC_ADDR_FLAGS, 32'hF);
      apb(1'b1, PWC_ADDR_CONTROL, 32'h21);
      seen = 3'h0;
      repeat (20) @(negedge clk) seen |= out_a;
      check("a runs", {31'h0, seen[1]}, 32'h1);
      apb(1'b1, 8'h0C, 32'h21);
      fault_input_pin[1] <= 1'b1;
      seen = 3'h0;
      repeat (20) @(negedge clk) seen |= out_a;
      check("a killed", {31'h0, seen[1]}, 32'h0);
      check("irq fault", {31'h0, irq_fault}, 32'h1);
      rdchk("flags", PWC_ADDR_FLAGS, 32'h5);
      fault_input_pin[1] <= 1'b0;
      apb(1'b1, PWC_ADDR_FLAGS, 32'h4);
      apb(1'b1, PWC_ADDR_CONTROL, 32'h20);
      apb(1'b1, PWC_ADDR_FLAGS, 32'h1);
      rdchk("flag clear", PWC_ADDR_FLAGS, 32'h0);
      apb(1'b1, 8'h08, 32'h71);
      comp_out[0] <= 1'b1;
      repeat (2) @(posedge clk);
      comp_out[0] <= 1'b0;
      repeat (8) @(posedge clk);
      rdchk("filtered", PWC_ADDR_FLAGS, 32'h0);
      comp_out[0] <= 1'b1;
      repeat (8) @(posedge clk);
      rdchk("comp event", PWC_ADDR_FLAGS, 32'h2);
      comp_out[0] <= 1'b0;
      apb(1'b1, PWC_ADDR_FLAGS, 32'hF);
      apb(1'b1, PWC_ADDR_CONTROL, 32'h21);
      apb(1'b1, 8'h10, 32'h24);
      fault_input_pin[2] <= 1'b1;
      seen = 3'h0;
      repeat (20) @(negedge clk) seen |= out_a | out_b;
      check("all killed", {29'h0, seen}, 32'h0);
      apb(1'b1, 8'h10, 32'h06);
      fault_input_pin[2] <= 1'b0;
      repeat (8) @(negedge clk);
      check("halted", {31'h0, running}, 32'h0);
      rdchk("run bit", PWC_ADDR_CONTROL, 32'h20);
      apb(1'b1, 8'h10, 32'h0);
      $display("done fault");
   endtask
   task automatic t_lock();
      apb(1'b1, PWC_ADDR_CONFIG, 32'h2C);
      apb(1'b1, PWC_ADDR_OUTEN, 32'h15);
      repeat (3) @(negedge clk);
      check("locked", {26'h0, out_pin_en}, 32'h0);
      apb(1'b1, PWC_ADDR_CONFIG, 32'h0C);
      repeat (3) @(negedge clk);
      check("unlocked", {26'h0, out_pin_en}, 32'h15);
      $display("done lock");
   endtask
   // module 1 A and B overlap in the ramp; only a cleared guard may let both show
   task automatic t_guard();
      apb(1'b1, PWC_ADDR_CONTROL, 32'h21);
      for (int g = 0; g < 2; g++)
      begin
         apb(1'b1, 8'h0C, 32'(g * 128));
         seen = 3'h0;
         repeat (20) @(negedge clk) seen |= out_a & out_b;
         check("overlap", {31'h0, seen[1]}, 32'(g));
      end
      apb(1'b1, PWC_ADDR_CONTROL, 32'h0);
      $display("done guard");
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // the longest measurement is 2048 cycles; allow ample margin
   initial
   begin
      #400000;
      num_errors++;
      final_report();
   end
   initial
   begin
      reset = 1'b1;
      {psel, penable, pwrite, slv} = 4'h0;
      clk_pll_en = 1'b1;
      paddr = 8'h0;
      pwdata = 32'h0;
      fault_input_pin = 3'h0;
      comp_out = 3'h0;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      t_regs();
      t_stage();
      t_timebase();
      t_halt();
      t_fault();
      t_lock();
      t_guard();
      final_report();
   end
endmodule
`default_nettype wire
